// *** shared/bcrtc_pkg.sv ***
/*
 Constants of the BCD calendar clock: register offsets, control field
 positions, reset values and timing counts.
 Assumes a 10 MHz system clock and a 32.768 kHz calendar source.
*/
package bcrtc_pkg;
   // ***********************************
   // Register offsets (byte wide)
   // ***********************************
   localparam logic [4:0] A_SSL = 5'h00;
   localparam logic [4:0] A_SSH = 5'h01;
   localparam logic [4:0] A_SEC = 5'h02;
   localparam logic [4:0] A_MIN = 5'h03;
   localparam logic [4:0] A_HOUR = 5'h04;
   localparam logic [4:0] A_WDAY = 5'h05;
   localparam logic [4:0] A_DATE = 5'h06;
   localparam logic [4:0] A_MON = 5'h07;
   localparam logic [4:0] A_YEAR = 5'h08;
   localparam logic [4:0] A_CTRL = 5'h09;
   localparam logic [4:0] A_STAT = 5'h0A;
   localparam logic [4:0] A_MASK = 5'h0B;
   localparam logic [4:0] A_WUTL = 5'h0C;
   localparam logic [4:0] A_WUTH = 5'h0D;
   localparam logic [4:0] A_ALMSK = 5'h0E;
   localparam logic [4:0] A_ALSEC = 5'h0F;
   localparam logic [4:0] A_ALMIN = 5'h10;
   localparam logic [4:0] A_ALHR = 5'h11;
   localparam logic [4:0] A_ALDATE = 5'h12;
   localparam logic [4:0] A_CALL = 5'h13;
   localparam logic [4:0] A_CALH = 5'h14;
   localparam logic [4:0] A_SHL = 5'h15;
   localparam logic [4:0] A_SHH = 5'h16;
   localparam logic [4:0] A_TFILT = 5'h17;
   localparam logic [4:0] A_CLKST = 5'h18;
   // ***********************************
   // Control bits and the hour PM bit
   // ***********************************
   localparam int C_RUN = 0;
   localparam int C_FMT12 = 1;
   localparam int C_WUTEN = 2;
   localparam int C_ALEN = 3;
   localparam int C_WSEL = 4;
   localparam int HR_PM = 6;
   // Status bits: alarm, wakeup, clock fail, tamper 0..2
   localparam int S_AL = 0;
   localparam int S_WUT = 1;
   localparam int S_CSS = 2;
   localparam int S_TAMP = 3;
   // ***********************************
   // Reset values
   // ***********************************
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam logic [7:0] DAY1_RST = 8'h01;
   localparam logic [15:0] WUT_RST = 16'hFFFF;
   // ***********************************
   // Timing
   // ***********************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int CSS_TIME_NS = 122070;
   localparam int CSS_CYC_I = (CSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [10:0] CSS_CYC = CSS_CYC_I[10:0];
   localparam logic [14:0] SS_TOP = 15'h7FFF;
endpackage

// *** design/bcrtc_top.sv ***
/*
 BCD calendar clock with subsecond count, shift, digital calibration,
 alarm, wakeup timer, crystal watchdog and three filtered tamper pins.
 Assumes oscillators and tamper pins are asynchronous pins, and a
 register master that follows the one-cycle strobe protocol.
*/
`timescale 1ns/1ps
module bcrtc_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [4:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic slow_external_crystal,
   input wire logic slow_internal_rc,
   input wire logic [2:0] tamper_pin,
   output logic [7:0] rd_data,
   output logic irq,
   output logic src_is_rc
);
   // ***********************************
   // Helpers
   // ***********************************
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction

   // Leap when BCD year divisible by four
   function automatic logic is_leap(input logic [7:0] y);
      is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                     : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] month_len(input logic [7:0] m, input logic lp);
      if (m == 8'h02) begin
         month_len = lp ? 8'h29 : 8'h28;
      end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
         month_len = 8'h30;
      end else begin
         month_len = 8'h31;
      end
   endfunction

   // ***********************************
   // Pin synchronisers and filters
   // ***********************************
   logic [4:0] pin_in;
   logic [4:0] pin_filt;
   logic [4:0] pin_rise;
   assign pin_in = {tamper_pin, slow_internal_rc, slow_external_crystal};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_pin
         logic [2:0] sync_reg;
         logic filt_reg;
         logic prev_reg;
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               sync_reg <= 3'h0;
               filt_reg <= 1'b0;
               prev_reg <= 1'b0;
            end else begin
               sync_reg <= {sync_reg[1:0], pin_in[gi]};
               if (sync_reg[1] == sync_reg[2]) begin
                  filt_reg <= sync_reg[2];
               end
               prev_reg <= filt_reg;
            end
         end
         assign pin_filt[gi] = filt_reg;
         assign pin_rise[gi] = filt_reg & ~prev_reg;
      end
   endgenerate

   // ***********************************
   // Clock watchdog and source select
   // ***********************************
   logic [10:0] css_cnt_reg;
   logic css_fail_reg;
   logic src_tick;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         css_cnt_reg <= 11'h000;
         css_fail_reg <= 1'b0;
      end else begin
         css_cnt_reg <= pin_rise[0] ? 11'h000 : (css_fail_reg ? css_cnt_reg : css_cnt_reg + 11'h001);
         if (css_cnt_reg == bcrtc_pkg::CSS_CYC) begin
            css_fail_reg <= 1'b1;
         end
      end
   end
   // Fallback is kept until reset: a flaky crystal must not toggle the source
   assign src_tick = css_fail_reg ? pin_rise[1] : pin_rise[0];

   // ***********************************
   // Registers
   // ***********************************
   logic [7:0] ctrl_reg, stat_reg, mask_reg, almsk_reg, tfilt_reg, shl_reg;
   logic [7:0] al_sec_reg, al_min_reg, al_hr_reg, al_date_reg;
   logic [15:0] wut_reg;
   logic [8:0] cal_reg;
   logic [14:0] shift_reg;
   logic [14:0] ss_reg;
   logic [19:0] calw_reg;
   logic [7:0] sec_reg, min_reg, hour_reg, wday_reg, date_reg, mon_reg, year_reg;
   logic [7:0] snap_reg [0:7];
   logic [7:0] rd_next;
   logic [5:0] ev_set;

   wire wr_ctrl = wr_stb && addr == bcrtc_pkg::A_CTRL;
   wire run = ctrl_reg[bcrtc_pkg::C_RUN];
   wire fmt12 = ctrl_reg[bcrtc_pkg::C_FMT12];
   wire cal_drop = calw_reg < {11'h000, cal_reg};
   wire cal_tick = run & src_tick & ~cal_drop & (shift_reg == 15'h0000);
   wire sec_tick = cal_tick & (ss_reg == bcrtc_pkg::SS_TOP);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_reg <= bcrtc_pkg::CTRL_RST;
         mask_reg <= 8'h00;
         almsk_reg <= 8'h0F;
         tfilt_reg <= 8'h00;
         shl_reg <= 8'h00;
         wut_reg <= bcrtc_pkg::WUT_RST;
         cal_reg <= 9'h000;
         al_sec_reg <= 8'h00;
         al_min_reg <= 8'h00;
         al_hr_reg <= 8'h00;
         al_date_reg <= 8'h00;
      end else if (wr_stb) begin
         if (wr_ctrl) ctrl_reg <= wdata;
         if (addr == bcrtc_pkg::A_MASK) mask_reg <= wdata;
         if (addr == bcrtc_pkg::A_ALMSK) almsk_reg <= wdata;
         if (addr == bcrtc_pkg::A_TFILT) tfilt_reg <= wdata;
         if (addr == bcrtc_pkg::A_SHL) shl_reg <= wdata;
         if (addr == bcrtc_pkg::A_WUTL) wut_reg[7:0] <= wdata;
         if (addr == bcrtc_pkg::A_WUTH) wut_reg[15:8] <= wdata;
         if (addr == bcrtc_pkg::A_CALL) cal_reg[7:0] <= wdata;
         if (addr == bcrtc_pkg::A_CALH) cal_reg[8] <= wdata[0];
         if (addr == bcrtc_pkg::A_ALSEC) al_sec_reg <= wdata;
         if (addr == bcrtc_pkg::A_ALMIN) al_min_reg <= wdata;
         if (addr == bcrtc_pkg::A_ALHR) al_hr_reg <= wdata;
         if (addr == bcrtc_pkg::A_ALDATE) al_date_reg <= wdata;
      end
   end

   // ***********************************
   // Shift, calibration window, subseconds
   // ***********************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         shift_reg <= 15'h0000;
         calw_reg <= 20'h00000;
         ss_reg <= 15'h0000;
      end else begin
         if (wr_stb && addr == bcrtc_pkg::A_SHH) begin
            shift_reg <= {wdata[6:0], shl_reg};
         end else if (run && src_tick && shift_reg != 15'h0000) begin
            shift_reg <= shift_reg - 15'h0001;
         end
         if (run && src_tick) calw_reg <= calw_reg + 20'h00001;
         if (wr_stb && addr == bcrtc_pkg::A_SSL) begin
            ss_reg <= 15'h0000;
         end else if (cal_tick) begin
            ss_reg <= ss_reg + 15'h0001;
         end
      end
   end

   // ***********************************
   // Calendar cascade
   // ***********************************
   wire leap = is_leap(year_reg);
   wire hr_wrap = fmt12 ? (hour_reg[5:0] == 6'h11 && hour_reg[bcrtc_pkg::HR_PM]) : (hour_reg == 8'h23);
   wire c_min = sec_tick & (sec_reg == 8'h59);
   wire c_hr = c_min & (min_reg == 8'h59);
   wire c_day = c_hr & hr_wrap;
   wire c_mon = c_day & (date_reg == month_len(mon_reg, leap));
   wire c_yr = c_mon & (mon_reg == 8'h12);
   logic [7:0] hour_next;
   always_comb begin
      hour_next = bcd_inc(hour_reg);
      if (!fmt12) begin
         hour_next = hr_wrap ? 8'h00 : bcd_inc(hour_reg);
      end else if (hour_reg[5:0] == 6'h11) begin
         hour_next = {1'b0, ~hour_reg[bcrtc_pkg::HR_PM], 6'h12};
      end else if (hour_reg[5:0] == 6'h12) begin
         hour_next = {1'b0, hour_reg[bcrtc_pkg::HR_PM], 6'h01};
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sec_reg <= 8'h00;
         min_reg <= 8'h00;
         hour_reg <= 8'h00;
         wday_reg <= bcrtc_pkg::DAY1_RST;
         date_reg <= bcrtc_pkg::DAY1_RST;
         mon_reg <= bcrtc_pkg::DAY1_RST;
         year_reg <= 8'h00;
      end else begin
         // Software writes win; set the calendar with RUN low to avoid a tick race
         if (wr_stb && addr == bcrtc_pkg::A_SEC) sec_reg <= wdata;
         else if (sec_tick) sec_reg <= c_min ? 8'h00 : bcd_inc(sec_reg);
         if (wr_stb && addr == bcrtc_pkg::A_MIN) min_reg <= wdata;
         else if (c_min) min_reg <= c_hr ? 8'h00 : bcd_inc(min_reg);
         if (wr_stb && addr == bcrtc_pkg::A_HOUR) hour_reg <= wdata;
         else if (c_hr) hour_reg <= hour_next;
         if (wr_stb && addr == bcrtc_pkg::A_WDAY) wday_reg <= wdata;
         else if (c_day) wday_reg <= (wday_reg == 8'h07) ? 8'h01 : bcd_inc(wday_reg);
         if (wr_stb && addr == bcrtc_pkg::A_DATE) date_reg <= wdata;
         else if (c_day) date_reg <= c_mon ? 8'h01 : bcd_inc(date_reg);
         if (wr_stb && addr == bcrtc_pkg::A_MON) mon_reg <= wdata;
         else if (c_mon) mon_reg <= c_yr ? 8'h01 : bcd_inc(mon_reg);
         if (wr_stb && addr == bcrtc_pkg::A_YEAR) year_reg <= wdata;
         else if (c_yr) year_reg <= (year_reg == 8'h99) ? 8'h00 : bcd_inc(year_reg);
      end
   end

   // ***********************************
   // Alarm
   // ***********************************
   wire al_hit = run & ctrl_reg[bcrtc_pkg::C_ALEN] & sec_tick
      & (almsk_reg[0] | al_sec_reg == sec_reg) & (almsk_reg[1] | al_min_reg == min_reg)
      & (almsk_reg[2] | al_hr_reg == hour_reg) & (almsk_reg[3] | al_date_reg == date_reg);

   // ***********************************
   // Wakeup timer
   // ***********************************
   logic [16:0] wut_cnt_reg;
   wire [2:0] wsel = ctrl_reg[bcrtc_pkg::C_WSEL +: 3];
   wire [3:0] wdiv_mask = 4'hF >> wsel[1:0];
   wire wut_step = wsel[2] ? sec_tick : cal_tick & ((ss_reg[3:0] | ~wdiv_mask) == 4'hF);
   // Zero reload is raised to one, so the shortest interval is two 61 us steps
   wire [16:0] wut_load = {wsel[2] & wsel[1], (wut_reg == 16'h0000) ? 16'h0001 : wut_reg};
   wire wut_en = ctrl_reg[bcrtc_pkg::C_WUTEN];
   wire wut_hit = wut_en & wut_step & (wut_cnt_reg == 17'h00000);
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wut_cnt_reg <= 17'h00000;
      end else if (!wut_en || wut_hit) begin
         wut_cnt_reg <= wut_load;
      end else if (wut_step) begin
         wut_cnt_reg <= wut_cnt_reg - 17'h00001;
      end
   end

   // ***********************************
   // Tamper filters
   // ***********************************
   logic [2:0] tamp_hit;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_tamp
         logic [3:0] tcnt_reg;
         logic tdone_reg;
         wire [3:0] tneed = 4'h1 << tfilt_reg[1:0];
         always_ff @(posedge clock) begin
            if (!rst_n || !pin_filt[2 + gi]) begin
               tcnt_reg <= 4'h0;
               tdone_reg <= 1'b0;
            end else if (tfilt_reg[1:0] == 2'h0) begin
               tdone_reg <= 1'b1;
            end else if (src_tick && !tdone_reg) begin
               tcnt_reg <= tcnt_reg + 4'h1;
               tdone_reg <= (tcnt_reg + 4'h1) == tneed;
            end
         end
         // One event per assertion of the pin
         assign tamp_hit[gi] = pin_filt[2 + gi] & ~tdone_reg
            & ((tfilt_reg[1:0] == 2'h0) | (src_tick & (tcnt_reg + 4'h1) == tneed));
      end
   endgenerate

   // ***********************************
   // Status, interrupt, read port
   // ***********************************
   logic css_prev_reg;
   assign ev_set = {tamp_hit, css_fail_reg & ~css_prev_reg, wut_hit, al_hit};
   wire [5:0] w1c = (wr_stb && addr == bcrtc_pkg::A_STAT) ? wdata[5:0] : 6'h00;
   wire [7:0] live [0:7];
   assign live[0] = ss_reg[7:0];
   assign live[1] = {1'b0, ss_reg[14:8]};
   assign live[2] = sec_reg;
   assign live[3] = min_reg;
   assign live[4] = hour_reg;
   assign live[5] = wday_reg;
   assign live[6] = date_reg;
   assign live[7] = mon_reg;
   logic [7:0] snap_year_reg;

   always_comb begin
      if (addr == bcrtc_pkg::A_SSL) rd_next = ss_reg[7:0];
      else if (addr <= bcrtc_pkg::A_MON) rd_next = snap_reg[addr[2:0]];
      else if (addr == bcrtc_pkg::A_YEAR) rd_next = snap_year_reg;
      else if (addr == bcrtc_pkg::A_CTRL) rd_next = ctrl_reg;
      else if (addr == bcrtc_pkg::A_STAT) rd_next = stat_reg;
      else if (addr == bcrtc_pkg::A_MASK) rd_next = mask_reg;
      else if (addr == bcrtc_pkg::A_WUTL) rd_next = wut_reg[7:0];
      else if (addr == bcrtc_pkg::A_WUTH) rd_next = wut_reg[15:8];
      else if (addr == bcrtc_pkg::A_ALMSK) rd_next = almsk_reg;
      else if (addr == bcrtc_pkg::A_ALSEC) rd_next = al_sec_reg;
      else if (addr == bcrtc_pkg::A_ALMIN) rd_next = al_min_reg;
      else if (addr == bcrtc_pkg::A_ALHR) rd_next = al_hr_reg;
      else if (addr == bcrtc_pkg::A_ALDATE) rd_next = al_date_reg;
      else if (addr == bcrtc_pkg::A_CALL) rd_next = cal_reg[7:0];
      else if (addr == bcrtc_pkg::A_CALH) rd_next = {7'h00, cal_reg[8]};
      else if (addr == bcrtc_pkg::A_SHL) rd_next = shift_reg[7:0];
      else if (addr == bcrtc_pkg::A_SHH) rd_next = {1'b0, shift_reg[14:8]};
      else if (addr == bcrtc_pkg::A_TFILT) rd_next = tfilt_reg;
      else if (addr == bcrtc_pkg::A_CLKST) rd_next = {6'h00, css_fail_reg, pin_filt[0]};
      else rd_next = 8'h00;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stat_reg <= 8'h00;
         css_prev_reg <= 1'b0;
         irq <= 1'b0;
         rd_data <= 8'h00;
         src_is_rc <= 1'b0;
         snap_year_reg <= 8'h00;
         // Snapshot starts at the calendar reset values, so reads before any freeze stay in range
         for (int i = 0; i < 8; i++) snap_reg[i] <= (i < 5) ? 8'h00 : bcrtc_pkg::DAY1_RST;
      end else begin
         css_prev_reg <= css_fail_reg;
         stat_reg[5:0] <= (stat_reg[5:0] & ~w1c) | ev_set;
         irq <= |(stat_reg[5:0] & mask_reg[5:0]);
         src_is_rc <= css_fail_reg;
         rd_data <= rd_stb ? rd_next : 8'h00;
         if (rd_stb && addr == bcrtc_pkg::A_SSL) begin
            for (int i = 0; i < 8; i++) snap_reg[i] <= live[i];
            snap_year_reg <= year_reg;
         end
      end
   end
endmodule // bcrtc_top

// *** test/bcrtc_top_props.sv ***
/*
 Checker for the calendar clock: watches the top ports only.
 Assumes one-cycle strobes and a crystal that is held low when it stops.
*/
`timescale 1ns/1ps
module bcrtc_top_props (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [4:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic slow_external_crystal,
   input wire logic slow_internal_rc,
   input wire logic [2:0] tamper_pin,
   input wire logic [7:0] rd_data,
   input wire logic irq,
   input wire logic src_is_rc
);
   // ***********************************
   // Helper logic
   // ***********************************
   // Margin covers the pin synchroniser and edge detect
   localparam int FAIL_LATE = bcrtc_pkg::CSS_CYC_I + 16;
   logic [11:0] quiet_reg;
   logic [7:0] mask_reg;
   wire quiet_top = (quiet_reg == 12'hFFF);
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         quiet_reg <= 12'h000;
         mask_reg <= 8'h00;
      end else begin
         quiet_reg <= (slow_external_crystal | quiet_top) ? (quiet_top ? quiet_reg : 12'h000) : quiet_reg + 12'h001;
         if (wr_stb && addr == bcrtc_pkg::A_MASK) begin
            mask_reg <= wdata;
         end
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ***********************************
   // Assertions
   // ***********************************
   a_rd_idle_zero: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
      else $error("read data not zero outside read answer");
   a_unmapped_zero: assert property (rd_stb && addr > bcrtc_pkg::A_CLKST |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property ($rose(rst_n) |-> !irq && !src_is_rc)
      else $error("outputs not idle after reset");
   a_source_sticky: assert property (src_is_rc |=> src_is_rc)
      else $error("clock source fell back to crystal");
   a_fail_switch: assert property (quiet_reg == FAIL_LATE[11:0] |-> src_is_rc)
      else $error("crystal loss not detected in time");
   a_fail_status: assert property (rd_stb && addr == bcrtc_pkg::A_CLKST && src_is_rc |=> rd_data[1])
      else $error("clock status misses failure");
   a_irq_masked: assert property (mask_reg == 8'h00 && $past(mask_reg) == 8'h00 |-> !irq)
      else $error("interrupt while fully masked");
   a_sec_bcd: assert property (rd_stb && addr == bcrtc_pkg::A_SEC |=> rd_data[7:4] <= 4'h5 && rd_data[3:0] <= 4'h9)
      else $error("seconds not BCD");
   a_wday_range: assert property (rd_stb && addr == bcrtc_pkg::A_WDAY |=> rd_data inside {[8'h01:8'h07]})
      else $error("weekday out of range");
   a_ssh_width: assert property (rd_stb && addr == bcrtc_pkg::A_SSH |=> !rd_data[7])
      else $error("subsecond wider than fifteen bits");
endmodule // bcrtc_top_props
bind bcrtc_top bcrtc_top_props u_bcrtc_top_props (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .slow_external_crystal(slow_external_crystal),
   .slow_internal_rc(slow_internal_rc), .tamper_pin(tamper_pin), .rd_data(rd_data), .irq(irq),
   .src_is_rc(src_is_rc));

// *** test/bcrtc_osc_model.sv ***
/*
 Oscillator model: crystal that can be stopped, and a free running RC.
 Assumes the bench controls xtal_run; periods are shortened for run time.
*/
`timescale 1ns/1ps
module bcrtc_osc_model #(
   parameter int XT_HALF_NS = 1000,
   parameter int RC_HALF_NS = 1300
) (
   input wire logic xtal_run,
   output logic slow_external_crystal,
   output logic slow_internal_rc
);
   initial slow_external_crystal = 1'b0;
   initial slow_internal_rc = 1'b0;
   // A failed crystal stands still low, it does not keep its last phase
   always #(XT_HALF_NS) slow_external_crystal = xtal_run ? ~slow_external_crystal : 1'b0;
   always #(RC_HALF_NS) slow_internal_rc = ~slow_internal_rc;
endmodule // bcrtc_osc_model

// *** test/bcrtc_top_bench.sv ***
/*
 Self-checking bench for the calendar clock top.
 Assumes the oscillator model on the far side and the one-cycle register bus.
*/
`timescale 1ns/1ps
module bcrtc_top_bench;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [2:0] tamper_pin = 3'h0;
   logic xtal_run = 1'b1;
   logic slow_external_crystal;
   logic slow_internal_rc;
   logic [7:0] rd_data;
   logic irq;
   logic src_is_rc;
   int fails = 0;
   int checks = 0;
   always #50 clock = ~clock;
   bcrtc_osc_model u_bcrtc_osc_model (.xtal_run(xtal_run), .slow_external_crystal(slow_external_crystal),
      .slow_internal_rc(slow_internal_rc));
   bcrtc_top u_bcrtc_top (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .slow_external_crystal(slow_external_crystal), .slow_internal_rc(slow_internal_rc),
      .tamper_pin(tamper_pin), .rd_data(rd_data), .irq(irq), .src_is_rc(src_is_rc));
   // ***********************************
   // Shared tasks
   // ***********************************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clock);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clock);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1 d = rd_data;
   endtask
   // Bounded wait on irq; running out is a mismatch
   task automatic wait_irq(input int limit, output int n);
      n = 0;
      while (irq !== 1'b1 && n < limit) begin
         @(posedge clock);
         #1 n++;
      end
      check("irq wait", {7'h00, irq}, 8'h01);
      // A wait that runs out ends the run at once
      if (irq !== 1'b1) end_of_test();
   endtask
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ***********************************
   // Scenarios
   // ***********************************
   task automatic t_reset();
      logic [4:0] a [10] = '{5'h09, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0C, 5'h0D, 5'h0E, 5'h0A, 5'h1F};
      logic [7:0] e [10] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h00};
      logic [7:0] v;
      for (int i = 0; i < 10; i++) begin
         rd(a[i], v);
         check("reset value", v, e[i]);
      end
      wr(5'h1F, 8'h5A);
      rd(5'h1F, v);
      check("unmapped", v, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_subsec();
      logic [7:0] v;
      repeat (200) @(posedge clock);
      rd(bcrtc_pkg::A_SSL, v);
      check("subsec runs", {7'h00, v != 8'h00}, 8'h01);
      wr(bcrtc_pkg::A_SSL, 8'h77);
      rd(bcrtc_pkg::A_SSL, v);
      check("subsec zeroed", {7'h00, v < 8'h02}, 8'h01);
      rd(bcrtc_pkg::A_SEC, v);
      check("snapshot sec", v, 8'h00);
      $display("t_subsec done");
   endtask
   task automatic t_shift();
      logic [7:0] v;
      wr(bcrtc_pkg::A_SHL, 8'h06);
      wr(bcrtc_pkg::A_SHH, 8'h00);
      wr(bcrtc_pkg::A_SSL, 8'h00);
      // At most four source pulses fall in this wait, all of them swallowed
      repeat (60) @(posedge clock);
      rd(bcrtc_pkg::A_SSL, v);
      check("shift holds", v, 8'h00);
      repeat (200) @(posedge clock);
      rd(bcrtc_pkg::A_SHL, v);
      check("shift done", v, 8'h00);
      rd(bcrtc_pkg::A_SSL, v);
      check("count resumes", {7'h00, v != 8'h00}, 8'h01);
      $display("t_shift done");
   endtask
   task automatic t_tamper();
      logic [7:0] v;
      int n;
      wr(bcrtc_pkg::A_MASK, 8'h38);
      wr(bcrtc_pkg::A_TFILT, 8'h00);
      for (int p = 0; p < 3; p++) begin
         @(posedge clock);
         tamper_pin <= 3'h1 << p;
         repeat (10) @(posedge clock);
         tamper_pin <= 3'h0;
         wait_irq(40, n);
         rd(bcrtc_pkg::A_STAT, v);
         check("tamper flag", v, 8'h08 << p);
         wr(bcrtc_pkg::A_STAT, 8'h08 << p);
         rd(bcrtc_pkg::A_STAT, v);
         check("tamper clear", v, 8'h00);
      end
      // Filter of two source pulses: a glitch shorter than one pulse period never counts
      wr(bcrtc_pkg::A_TFILT, 8'h01);
      tamper_pin <= 3'h1;
      repeat (10) @(posedge clock);
      tamper_pin <= 3'h0;
      repeat (10) @(posedge clock);
      rd(bcrtc_pkg::A_STAT, v);
      check("tamper glitch", v, 8'h00);
      tamper_pin <= 3'h1;
      repeat (60) @(posedge clock);
      tamper_pin <= 3'h0;
      wait_irq(40, n);
      rd(bcrtc_pkg::A_STAT, v);
      check("tamper filtered", v, 8'h08);
      wr(bcrtc_pkg::A_STAT, 8'h08);
      repeat (2) @(posedge clock);
      check("irq released", {7'h00, irq}, 8'h00);
      $display("t_tamper done");
   endtask
   task automatic t_wakeup();
      logic [7:0] v;
      int n;
      wr(bcrtc_pkg::A_MASK, 8'h02);
      wr(bcrtc_pkg::A_WUTL, 8'h01);
      wr(bcrtc_pkg::A_WUTH, 8'h00);
      // Run, wakeup enable, finest step of two pulses
      wr(bcrtc_pkg::A_CTRL, 8'h35);
      wait_irq(400, n);
      rd(bcrtc_pkg::A_STAT, v);
      check("wakeup flag", v & 8'h02, 8'h02);
      wr(bcrtc_pkg::A_CTRL, 8'h01);
      wr(bcrtc_pkg::A_STAT, 8'h02);
      rd(bcrtc_pkg::A_STAT, v);
      check("wakeup clear", v, 8'h00);
      $display("t_wakeup done");
   endtask
   task automatic t_css();
      logic [7:0] v;
      int n;
      wr(bcrtc_pkg::A_MASK, 8'h04);
      xtal_run <= 1'b0;
      wait_irq(2000, n);
      check("not early", {7'h00, n >= bcrtc_pkg::CSS_CYC_I - 40}, 8'h01);
      check("on rc", {7'h00, src_is_rc}, 8'h01);
      rd(bcrtc_pkg::A_CLKST, v);
      check("fail status", v & 8'h02, 8'h02);
      rd(bcrtc_pkg::A_STAT, v);
      check("fail flag", v, 8'h04);
      xtal_run <= 1'b1;
      repeat (100) @(posedge clock);
      check("still rc", {7'h00, src_is_rc}, 8'h01);
      rst_n <= 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1 check("reset source", {7'h00, src_is_rc}, 8'h00);
      $display("t_css done");
   endtask
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_subsec();
      t_shift();
      t_tamper();
      t_wakeup();
      t_css();
      end_of_test();
   end
endmodule // bcrtc_top_bench
